// [rtl/qwd_pkg.sv]
// constants and carrier types for the quadrature wheel decoder
package qwd_pkg;

  // register offsets
  localparam logic [7:0] QWD_OFF_COUNT = 8'hd0;
  localparam logic [7:0] QWD_OFF_CFG = 8'hd1;
  localparam logic [7:0] QWD_OFF_SEL_A = 8'hd2;
  localparam logic [7:0] QWD_OFF_SEL_B = 8'hd3;
  localparam logic [7:0] QWD_OFF_RSVD = 8'hd6;
  localparam logic [7:0] QWD_OFF_ACC = 8'hd7;
  localparam logic [7:0] QWD_OFF_LOAD = 8'hd8;
  localparam logic [7:0] QWD_OFF_SYSRST = 8'h60;

  // field positions
  localparam int QWD_CFG_FILT_LSB = 0;
  localparam int QWD_CFG_POLA_BIT = 4;
  localparam int QWD_CFG_SHUT_BIT = 5;
  localparam int QWD_SYSRST_DEC_BIT = 5;
  localparam int QWD_ACC_BIT = 0;
  localparam int QWD_LOAD_BIT = 0;

  // reset values
  localparam logic [7:0] QWD_RST_COUNT = 8'h00;
  localparam logic [7:0] QWD_RST_CNTR = 8'h00;
  localparam logic [2:0] QWD_RST_FILT = 3'h0;
  localparam logic QWD_RST_POLA = 1'b0;
  localparam logic QWD_RST_SHUT = 1'b0;
  localparam logic [2:0] QWD_RST_SEL_A = 3'h0;
  localparam logic [2:0] QWD_RST_SEL_B = 3'h1;
  localparam logic QWD_RST_ACC = 1'b1;
  localparam logic QWD_RST_DEC = 1'b0;

  // pin selector code with no pin behind it
  localparam logic [2:0] QWD_SEL_RSVD = 3'h5;

  // debounce: a level must last 2^(n+1)*3 slow periods,
  // sampled every 2^n periods, so 2*3 samples in a row
  localparam int QWD_FILT_MULT = 3;
  localparam logic [2:0] QWD_FILT_SAMPLES = 3'(2 * QWD_FILT_MULT);

  typedef struct packed {
    logic shuttle;
    logic pola;
    logic [2:0] filt;
  } qwd_cfg_s;

  typedef struct packed {
    logic up;
    logic dn;
  } qwd_step_s;

  typedef enum logic {
    QWD_LOAD_IDLE = 1'b0,
    QWD_LOAD_PEND = 1'b1
  } qwd_load_e;

endpackage : qwd_pkg

// [rtl/qwd_quad_wheel_decoder.sv]
// quadrature wheel decoder: pin select, debounce, counter, registers
`timescale 1ns/1ps

// What this block does
// - each phase picks one of seven pins by its own 3-bit selector; code 5 reads idle
// - the live position counter is hidden from the register bus
// - common mode steps once after both phases show matching edges
// - double accuracy mode steps on every edge of either phase, except flips of both phases on the same sample
// - writing one to load copies the counter into the count register
// - the load bit returns to zero by itself once the copy is done
// - reading the count register returns it and then clears it
// - the decoder reset bit in the system reset register zeroes counter
// - a 3-bit filter field n sets the debounce window
// - levels shorter than 2^(n+1)*3 slow periods are ignored as jitter
// - inputs are sampled on the slow clock divided by 2^n
// - polarity bit gives the idle input level, low or high
// - shuttle mode counts non-overlapping pulses on the two phases
// - filter, sample divider and counter steps advance on slow clock ticks; the decoder reset clears the counter on any system cycle
// - reset leaves double accuracy on, channel a code 0, b code 1
module qwd_quad_wheel_decoder
  import qwd_pkg::*;
(
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // slow clock and candidate phase pins
  input wire logic SLOW_CLOCK,
  input wire logic [7:0] PIN_IN,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA
);

  // ---------------- pin and slow clock synchronisers
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [8:0] sync3_r;
  logic [8:0] stable_r;
  wire logic [8:0] async_in = {SLOW_CLOCK, PIN_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          stable_r[gi] <= 1'b0;
        end else if (CLK_EN) begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          // a change counts only once two stages agree
          if (sync2_r[gi] == sync3_r[gi]) begin
            stable_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  wire logic [7:0] pin_val = stable_r[7:0];
  wire logic slow_lvl = stable_r[8];
  wire logic slow_rise = sync2_r[8] & sync3_r[8];
  // one system cycle per rising edge of the slow clock
  wire logic slow_tick = CLK_EN & ~slow_lvl & slow_rise;

  // ---------------- software registers
  qwd_cfg_s cfg_r;
  logic [2:0] sel_a_r;
  logic [2:0] sel_b_r;
  logic acc_r;
  logic dec_rst_r;
  qwd_load_e load_r;
  qwd_load_e load_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] cntr_r;
  logic [7:0] cntr_nxt;
  logic [7:0] rdata_nxt;

  wire logic wr_cfg = REG_WR && REG_ADDR == QWD_OFF_CFG;
  wire logic wr_sel_a = REG_WR && REG_ADDR == QWD_OFF_SEL_A;
  wire logic wr_sel_b = REG_WR && REG_ADDR == QWD_OFF_SEL_B;
  wire logic wr_acc = REG_WR && REG_ADDR == QWD_OFF_ACC;
  wire logic wr_load = REG_WR && REG_ADDR == QWD_OFF_LOAD;
  wire logic wr_sysrst = REG_WR && REG_ADDR == QWD_OFF_SYSRST;
  wire logic rd_count = REG_RD && REG_ADDR == QWD_OFF_COUNT;

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      cfg_r.filt <= QWD_RST_FILT;
      cfg_r.pola <= QWD_RST_POLA;
      cfg_r.shuttle <= QWD_RST_SHUT;
      sel_a_r <= QWD_RST_SEL_A;
      sel_b_r <= QWD_RST_SEL_B;
      acc_r <= QWD_RST_ACC;
      dec_rst_r <= QWD_RST_DEC;
    end else if (CLK_EN) begin
      if (wr_cfg) begin
        cfg_r.filt <= REG_WDATA[QWD_CFG_FILT_LSB +: 3];
        cfg_r.pola <= REG_WDATA[QWD_CFG_POLA_BIT];
        cfg_r.shuttle <= REG_WDATA[QWD_CFG_SHUT_BIT];
      end
      if (wr_sel_a) begin
        sel_a_r <= REG_WDATA[2:0];
      end
      if (wr_sel_b) begin
        sel_b_r <= REG_WDATA[2:0];
      end
      if (wr_acc) begin
        acc_r <= REG_WDATA[QWD_ACC_BIT];
      end
      if (wr_sysrst) begin
        dec_rst_r <= REG_WDATA[QWD_SYSRST_DEC_BIT];
      end
    end
  end

  // ---------------- sample divider: slow clock / 2^n
  logic [7:0] div_r;
  wire logic [7:0] div_mask = 8'((9'h001 << cfg_r.filt) - 9'h001);
  wire logic sample_tick = slow_tick && ((div_r & div_mask) == div_mask);

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      div_r <= 8'h00;
    end else if (slow_tick) begin
      div_r <= div_r + 8'h01;
    end
  end

  // ---------------- per-phase select, polarity and debounce
  // index 0 is phase a, index 1 is phase b
  logic [1:0] raw_w;
  logic [1:0] filt_r;
  logic [1:0] flip_w;
  logic [2:0] run_r [2];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_phase
      wire logic [2:0] sel = (gi == 0) ? sel_a_r : sel_b_r;
      // the reserved code sees a permanently idle input
      wire logic pin = (sel == QWD_SEL_RSVD) ? cfg_r.pola : pin_val[sel];
      // after this xor, idle is always low inside the block
      assign raw_w[gi] = pin ^ cfg_r.pola;
      wire logic last = run_r[gi] == QWD_FILT_SAMPLES - 3'h1;
      assign flip_w[gi] = sample_tick && raw_w[gi] != filt_r[gi] && last;

      always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
          run_r[gi] <= 3'h0;
          filt_r[gi] <= 1'b0;
        end else if (sample_tick) begin
          if (raw_w[gi] == filt_r[gi]) begin
            run_r[gi] <= 3'h0;
          end else if (last) begin
            run_r[gi] <= 3'h0;
            filt_r[gi] <= raw_w[gi];
          end else begin
            run_r[gi] <= run_r[gi] + 3'h1;
          end
        end
      end
    end
  endgenerate

  // ---------------- edge direction
  // a leading b counts up; simultaneous flips carry no direction
  wire logic new_a = filt_r[0] ^ flip_w[0];
  wire logic new_b = filt_r[1] ^ flip_w[1];
  wire logic only_a = flip_w[0] & ~flip_w[1];
  wire logic only_b = flip_w[1] & ~flip_w[0];
  qwd_step_s step_w;

  always_comb begin
    step_w.up = 1'b0;
    step_w.dn = 1'b0;
    if (cfg_r.shuttle) begin
      // pulses alternate without overlap: a adds, b subtracts
      step_w.up = only_a && (new_a || acc_r);
      step_w.dn = only_b && (new_b || acc_r);
    end else if (acc_r) begin
      step_w.up = (only_a && new_a != filt_r[1]) ||
                  (only_b && new_b == filt_r[0]);
      step_w.dn = (only_a && new_a == filt_r[1]) ||
                  (only_b && new_b != filt_r[0]);
    end else begin
      // count only when the second phase catches up with the first
      step_w.up = only_b && new_b == filt_r[0];
      step_w.dn = only_a && new_a == filt_r[1];
    end
  end

  // ---------------- hidden counter and load handshake
  wire logic load_go = load_r == QWD_LOAD_PEND && slow_tick;

  always_comb begin
    cntr_nxt = cntr_r;
    if (dec_rst_r) begin
      cntr_nxt = QWD_RST_CNTR;
    end else if (step_w.up) begin
      cntr_nxt = cntr_r + 8'h01;
    end else if (step_w.dn) begin
      cntr_nxt = cntr_r - 8'h01;
    end
  end

  always_comb begin
    case (load_r)
      QWD_LOAD_IDLE: begin
        load_nxt = (wr_load && REG_WDATA[QWD_LOAD_BIT]) ?
                   QWD_LOAD_PEND : QWD_LOAD_IDLE;
      end
      QWD_LOAD_PEND: begin
        // copy happens on the decoder's own tick, then self-clears
        load_nxt = slow_tick ? QWD_LOAD_IDLE : QWD_LOAD_PEND;
      end
      default: begin
        load_nxt = QWD_LOAD_IDLE;
      end
    endcase
  end

  // a load in the same cycle as a clearing read wins
  always_comb begin
    count_nxt = count_r;
    if (load_go) begin
      count_nxt = cntr_r;
    end else if (rd_count) begin
      count_nxt = QWD_RST_COUNT;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      cntr_r <= QWD_RST_CNTR;
      load_r <= QWD_LOAD_IDLE;
      count_r <= QWD_RST_COUNT;
    end else if (CLK_EN) begin
      cntr_r <= cntr_nxt;
      load_r <= load_nxt;
      count_r <= count_nxt;
    end
  end

  // ---------------- read port: data only in the cycle after the strobe
  wire logic [7:0] cfg_rd = {2'b00, cfg_r.shuttle, cfg_r.pola, 1'b0,
                             cfg_r.filt};

  always_comb begin
    case (REG_ADDR)
      QWD_OFF_COUNT: rdata_nxt = count_r;
      QWD_OFF_CFG: rdata_nxt = cfg_rd;
      QWD_OFF_SEL_A: rdata_nxt = {5'h00, sel_a_r};
      QWD_OFF_SEL_B: rdata_nxt = {5'h00, sel_b_r};
      QWD_OFF_ACC: rdata_nxt = {7'h00, acc_r};
      QWD_OFF_LOAD: rdata_nxt = {7'h00, load_r};
      QWD_OFF_SYSRST: rdata_nxt = {2'b00, dec_rst_r, 5'h00};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else if (CLK_EN) begin
      REG_RDATA <= REG_RD ? rdata_nxt : 8'h00;
    end
  end

  // ---------------- assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  AST_LOAD_COPY: assert property (
    CLK_EN && load_go |=> count_r == $past(cntr_r))
    else $error("load did not copy the counter");

  AST_LOAD_SELF_CLEAR: assert property (
    CLK_EN && load_go && !REG_RD |=>
      load_r == QWD_LOAD_IDLE && REG_RDATA == 8'h00)
    else $error("load bit did not clear after the copy");

  AST_READ_CLEARS: assert property (
    CLK_EN && rd_count && !load_go |=>
      count_r == 8'h00 && REG_RDATA == $past(count_r))
    else $error("count read did not return and clear");

  AST_DEC_RESET: assert property (
    CLK_EN && dec_rst_r |=> cntr_r == 8'h00)
    else $error("decoder reset did not zero the counter");

  AST_DOUBLE_UP: assert property (
    CLK_EN && acc_r && !cfg_r.shuttle && !dec_rst_r && only_a &&
      new_a != filt_r[1] |=> cntr_r == $past(cntr_r) + 8'h01)
    else $error("double mode edge did not count up");

  AST_COMMON_HOLD: assert property (
    CLK_EN && !acc_r && !cfg_r.shuttle && !dec_rst_r && only_a &&
      new_a != filt_r[1] |=> $stable(cntr_r))
    else $error("common mode counted on the leading phase");

  AST_FILTER_RUN: assert property (
    CLK_EN && $changed(filt_r[0]) |->
      $past(run_r[0]) == QWD_FILT_SAMPLES - 3'h1 && $past(sample_tick))
    else $error("phase a accepted before the debounce run");

  AST_RSVD_IDLE: assert property (
    sel_a_r == QWD_SEL_RSVD |-> raw_w[0] == 1'b0)
    else $error("reserved selector did not read idle");

  AST_SHUTTLE_DOWN: assert property (
    CLK_EN && cfg_r.shuttle && !dec_rst_r && only_b && new_b
      |=> cntr_r == $past(cntr_r) - 8'h01)
    else $error("shuttle pulse on b did not count down");

  AST_RDATA_ONCE: assert property (
    CLK_EN && !REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data outside the answer cycle");

endmodule : qwd_quad_wheel_decoder

// [verif/qwd_enc_model.sv]
// wheel encoder model driving the two phases onto the candidate pins
`timescale 1ns/1ps
module qwd_enc_model
  import qwd_pkg::*;
#(
  parameter int SLOW_P = 16
)
(
  // clock
  input wire logic SYS_CLK,
  // wiring of the phases to pins
  input wire logic [2:0] SEL_A,
  input wire logic [2:0] SEL_B,
  input wire logic POLA,
  input wire logic [7:0] NOISE,
  // candidate pins
  output logic [7:0] PIN_IN
);
  logic pa = 1'b0;
  logic pb = 1'b0;

  // unselected pins toggle at random so a wrong pick shows up
  always_comb begin
    PIN_IN = NOISE;
    PIN_IN[SEL_A] = pa ^ POLA;
    PIN_IN[SEL_B] = pb ^ POLA;
  end

  // gray-code quarter steps, each level held twice the jitter window
  task automatic move(input logic fwd, input int edges, input int n);
    for (int i = 0; i < edges; i++) begin
      repeat (SLOW_P * (12 << n)) @(posedge SYS_CLK);
      if (pa ^ pb ^ fwd) pa <= ~pa;
      else pb <= ~pb;
    end
    repeat (SLOW_P * (12 << n)) @(posedge SYS_CLK);
  endtask : move

  // single pulse on one phase; short lengths act as jitter
  task automatic pulse(input logic on_b, input int len, input int n);
    if (on_b) pb <= 1'b1;
    else pa <= 1'b1;
    repeat (SLOW_P * len) @(posedge SYS_CLK);
    if (on_b) pb <= 1'b0;
    else pa <= 1'b0;
    repeat (SLOW_P * (12 << n)) @(posedge SYS_CLK);
  endtask : pulse
endmodule : qwd_enc_model

// [verif/qwd_quad_wheel_decoder_tb.sv]
// self-checking bench for the quadrature wheel decoder
`timescale 1ns/1ps
module qwd_quad_wheel_decoder_tb
  import qwd_pkg::*;
;
  // slow clock far faster than 32 kHz to keep the run short
  localparam int SLOW_P = 16;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic [7:0] pins;
  logic [3:0] slow_cnt = 4'h0;
  logic [31:0] rnd = 32'h0000_93b7;
  logic [2:0] sa = 3'h0;
  logic [2:0] sb = 3'h1;
  logic pola = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int num_checks = 0;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  always #4 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    slow_cnt <= slow_cnt + 4'h1;
    rnd <= lfsr(rnd);
  end

  qwd_quad_wheel_decoder i_dut (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(1'b1),
    .SLOW_CLOCK(slow_cnt[3]), .PIN_IN(pins), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA)
  );

  qwd_enc_model #(.SLOW_P(SLOW_P)) i_enc (
    .SYS_CLK(SYS_CLK), .SEL_A(sa), .SEL_B(sb), .POLA(pola),
    .NOISE(rnd[7:0]), .PIN_IN(pins)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : chk

  // read data stands only in the cycle after the strobe
  always @(posedge SYS_CLK) begin
    rd_q <= REG_RD;
    if (rd_q) chk(REG_RDATA, exp_q.pop_front());
  end

  // strobes stay up between back-to-back calls; rest drops them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_WR <= 1'b1;
    REG_RD <= 1'b0;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    REG_WR <= 1'b0;
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    exp_q.push_back(e);
    @(posedge SYS_CLK);
  endtask : rd

  task automatic rest(input int c);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    repeat (c) @(posedge SYS_CLK);
  endtask : rest

  task automatic grab(input logic [7:0] e);
    wr(QWD_OFF_LOAD, 8'h01);
    rest(2 * SLOW_P + 8);
    rd(QWD_OFF_LOAD, 8'h00);
    rd(QWD_OFF_COUNT, e);
    rd(QWD_OFF_COUNT, 8'h00);
    rest(1);
  endtask : grab

  task automatic clear_cntr();
    wr(QWD_OFF_SYSRST, 8'h20);
    wr(QWD_OFF_SYSRST, 8'h00);
  endtask : clear_cntr

  task automatic test_done();
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge SYS_CLK);
    err_total++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    rd(QWD_OFF_CFG, 8'h00);
    rd(QWD_OFF_SEL_A, 8'h00);
    rd(QWD_OFF_SEL_B, 8'h01);
    rd(QWD_OFF_ACC, 8'h01);
    rd(QWD_OFF_COUNT, 8'h00);
    rd(8'h55, 8'h00);
    wr(QWD_OFF_RSVD, 8'hff);
    rd(QWD_OFF_RSVD, 8'h00);
    // random distinct pins, never the reserved code
    sa <= (rnd[2:0] == 3'h5) ? 3'h6 : rnd[2:0];
    sb <= (rnd[5:3] == 3'h5) ? 3'h7 : rnd[5:3];
    rest(1);
    while (sb == sa || sb == 3'h5) sb = sb + 3'h1;
    wr(QWD_OFF_SEL_A, {5'h00, sa});
    wr(QWD_OFF_SEL_B, {5'h00, sb});
    rd(QWD_OFF_SEL_B, {5'h00, sb});
    rest(1);
    i_enc.move(1'b1, 8, 0);
    rd(QWD_OFF_COUNT, 8'h00);
    rest(1);
    grab(8'h08);
    i_enc.move(1'b0, 12, 0);
    grab(8'hfc);
    clear_cntr();
    grab(8'h00);
    wr(QWD_OFF_ACC, 8'h00);
    rest(1);
    i_enc.move(1'b1, 8, 0);
    grab(8'h04);
    i_enc.move(1'b0, 4, 0);
    grab(8'h02);
    wr(QWD_OFF_ACC, 8'h01);
    clear_cntr();
    wr(QWD_OFF_CFG, 8'h11);
    rd(QWD_OFF_CFG, 8'h11);
    pola <= 1'b1;
    rest(1);
    i_enc.pulse(1'b0, 5, 1);
    i_enc.move(1'b1, 4, 1);
    grab(8'h04);
    clear_cntr();
    wr(QWD_OFF_CFG, 8'h20);
    pola <= 1'b0;
    rest(1);
    i_enc.pulse(1'b0, 12, 0);
    i_enc.pulse(1'b0, 12, 0);
    i_enc.pulse(1'b1, 12, 0);
    grab(8'h02);
    // let the last read answer be compared before the verdict
    rest(2);
    test_done();
  end
endmodule : qwd_quad_wheel_decoder_tb
